// File: dv/coef_bank_checker_assertions.sv
// assertions on the bank switch controller's ports
// bound to coefficient_bank_switch_control; one clock, synchronous reset
`timescale 1ns/1ps

module coef_bank_checker
(
  input wire logic                                                 sys_clk,
  input wire logic                                                 rst,
  input wire logic                                                 regWrEn,
  input wire logic                                                 regRdEn,
  input wire logic [coef_bank_pkg::REG_ADDR_W-1:0]                 regAddr,
  input wire logic [coef_bank_pkg::REG_DATA_W-1:0]                 regWrData,
  input wire logic [coef_bank_pkg::REG_DATA_W-1:0]                 regRdData,
  input wire logic                                                 audioStreaming,
  input wire logic                                                 muteDone,
  input wire logic                                                 unmuteDone,
  input wire logic                                                 muteRequest,
  input wire logic [coef_bank_pkg::NUM_CHANNELS*coef_bank_pkg::VOL_W-1:0] volApplied,
  input wire logic [coef_bank_pkg::BANK_W-1:0]                     activeBank,
  input wire logic                                                 switchBusy
);
  import coef_bank_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic bankWr = regWrEn && regAddr == BANK_CTRL_OFFSET;

  property manual_pick_p;
    logic [1:0] b;
    (bankWr && !regWrData[18] && regWrData[17:16] != 2'h3 && !audioStreaming
      && !switchBusy, b = regWrData[17:16]) |-> ##2 activeBank == b;
  endproperty

  reset_state_a:
    assert property (disable iff (1'b0) rst |=> activeBank == BANK_ONE && !switchBusy)
    else $error("state not cleared by reset");
  bank_range_a:
    assert property (activeBank != 2'h3) else $error("active bank out of range");
  mute_vol_zero_a:
    assert property (muteRequest |-> volApplied == '0) else $error("volume not muted");
  switch_mute_a:
    assert property ($rose(switchBusy) |-> muteRequest) else $error("switch without mute");
  swap_after_mute_a:
    assert property ($changed(activeBank) && $past(switchBusy) && $past(audioStreaming)
      |-> $past(muteDone)) else $error("bank swapped before mute ramp");
  busy_until_unmute_a:
    assert property (switchBusy && !muteRequest && !unmuteDone && audioStreaming
      |=> switchBusy) else $error("switch ended before unmute ramp");
  manual_pick_a:
    assert property (manual_pick_p) else $error("manual selection not applied");
  set_inhibit_a:
    assert property (bankWr && regWrData[18] && regWrData[17:16] != 2'h3 && !switchBusy
      |-> ##2 $stable(activeBank)[*2]) else $error("bank switched in bank-set mode");
  read_status_a:
    assert property (regRdEn && regAddr == BANK_CTRL_OFFSET |=> regRdData[26:24] ==
      {$past(switchBusy), $past(activeBank)}) else $error("status fields wrong on read");

  cover property (muteRequest && muteDone);
  cover property ($fell(switchBusy));
  cover property (activeBank == BANK_THREE);
  cover property ($fell(muteRequest) && !audioStreaming);
endmodule

bind coefficient_bank_switch_control coef_bank_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .audioStreaming(audioStreaming), .muteDone(muteDone),
  .unmuteDone(unmuteDone), .muteRequest(muteRequest), .volApplied(volApplied),
  .activeBank(activeBank), .switchBusy(switchBusy));

// File: dv/ramp_model.sv
// stand-in for the volume ramp engine answering mute and unmute requests
// assumes the controller holds muteRequest and switchBusy as levels
`timescale 1ns/1ps

module ramp_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       muteRequest,
  input  wire logic       switchBusy,
  input  wire logic [7:0] rampLen,
  output logic            muteDone,
  output logic            unmuteDone
);
  logic [7:0] count;

  // each ramp lasts rampLen+1 cycles and ends with one done pulse
  always_ff @(posedge sys_clk)
  begin
    muteDone <= 1'b0;
    unmuteDone <= 1'b0;
    count <= count + 8'h01;
    if (rst || !switchBusy || muteDone || unmuteDone)
      count <= 8'h00;
    else if (count == rampLen)
    begin
      muteDone <= muteRequest;
      unmuteDone <= !muteRequest;
    end
  end
endmodule

// File: dv/tb.sv
// self-checking bench for the bank switch controller
// drives inputs on falling edges; ramp_model answers the mute and unmute ramps
`timescale 1ns/1ps

module tb;
  import coef_bank_pkg::*;
  logic         sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic         coefWrEn = 1'b0, audioStreaming = 1'b0, volWrEn = 1'b0;
  logic         muteDone, unmuteDone, muteRequest, switchBusy;
  logic [7:0]   regAddr = 8'h00;
  logic [31:0]  regWrData = '0, coefWrData = '0, regRdData, procRdData;
  logic [8:0]   coefAddr = '0, procRdAddr = '0;
  logic [2:0]   rateCode = 3'h0, volChannel = 3'h0;
  logic [15:0]  volLevel = '0;
  logic [127:0] volApplied;
  logic [1:0]   activeBank;
  int           err_count = 0, check_count = 0;

  coefficient_bank_switch_control u_dut (.sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .coefWrEn(coefWrEn), .coefAddr(coefAddr), .coefWrData(coefWrData),
    .procRdAddr(procRdAddr), .procRdData(procRdData), .rateCode(rateCode),
    .audioStreaming(audioStreaming), .volWrEn(volWrEn), .volChannel(volChannel),
    .volLevel(volLevel), .muteDone(muteDone), .unmuteDone(unmuteDone),
    .muteRequest(muteRequest), .volApplied(volApplied), .activeBank(activeBank),
    .switchBusy(switchBusy));
  ramp_model u_ramp (.sys_clk(sys_clk), .rst(rst), .muteRequest(muteRequest),
    .switchBusy(switchBusy), .rampLen(8'h1E), .muteDone(muteDone), .unmuteDone(unmuteDone));

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] d);
    regWrEn = 1'b1;
    regAddr = BANK_CTRL_OFFSET;
    regWrData = d;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    chk("regRdData", exp, regRdData);
  endtask
  task automatic cw(input logic [8:0] a, input logic [31:0] d);
    coefWrEn = 1'b1;
    coefAddr = a;
    coefWrData = d;
    @(negedge sys_clk);
    coefWrEn = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic pr(input logic [8:0] a, input logic [31:0] exp);
    procRdAddr = a;
    @(negedge sys_clk);
    chk("procRdData", exp, procRdData);
  endtask
  task automatic vw(input logic [2:0] c, input logic [15:0] v);
    volWrEn = 1'b1;
    volChannel = c;
    volLevel = v;
    @(negedge sys_clk);
    volWrEn = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic bank(input logic [1:0] b);
    chk("activeBank", {30'h0, b}, {30'h0, activeBank});
  endtask

  task automatic t_bankset();
    rd(8'h40, 32'h0000_FF00);
    rd(8'h44, 32'h0);
    wr(32'h0004_8040);
    cw(9'h005, 32'h0000_00A1);
    wr(32'h0005_8040);
    cw(9'h005, 32'h0000_00B2);
    wr(32'h0006_8040);
    cw(9'h005, 32'h0000_00C3);
    bank(BANK_ONE);
    pr(9'h005, 32'h0000_00A1);
    rd(8'h40, 32'h0006_8040);
  endtask
  task automatic t_stream();
    audioStreaming = 1'b1;
    vw(3'h0, 16'h1234);
    vw(3'h1, 16'h0055);
    wr(32'h0001_8040);
    @(negedge sys_clk);
    chk("muteRequest", 32'h1, {31'h0, muteRequest});
    vw(3'h1, 16'h0077);
    chk("volApplied", 32'h0, volApplied[31:0]);
    bank(BANK_ONE);
    repeat (100) if (switchBusy !== 1'b0) @(negedge sys_clk);
    chk("switchBusy", 32'h0, {31'h0, switchBusy});
    bank(BANK_TWO);
    chk("volApplied", 32'h0077_1234, volApplied[31:0]);
    pr(9'h005, 32'h0000_00B2);
  endtask
  task automatic t_stopped();
    audioStreaming = 1'b0;
    wr(32'h0002_8040);
    @(negedge sys_clk);
    bank(BANK_THREE);
    chk("switchBusy", 32'h0, {31'h0, switchBusy});
    cw(9'h006, 32'h0000_00D4);
    pr(9'h006, 32'h0000_00D4);
    pr(9'h005, 32'h0000_00C3);
  endtask
  task automatic t_cut();
    audioStreaming = 1'b1;
    wr(32'h0000_8040);
    @(negedge sys_clk);
    chk("muteRequest", 32'h1, {31'h0, muteRequest});
    audioStreaming = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("switchBusy", 32'h0, {31'h0, switchBusy});
    bank(BANK_ONE);
    chk("volApplied", 32'h0077_1234, volApplied[31:0]);
    pr(9'h005, 32'h0000_00A1);
  endtask
  task automatic t_auto();
    wr(32'h0003_8040);
    for (int r = 0; r < 8; r++)
    begin
      rateCode = 3'(r);
      repeat (3) @(negedge sys_clk);
      bank(r == 0 ? BANK_ONE : r == 1 ? BANK_TWO : BANK_THREE);
    end
    rateCode = 3'h1;
    repeat (3) @(negedge sys_clk);
    cw(9'h007, 32'h0000_00E5);
    pr(9'h007, 32'h0000_00E5);
    wr(32'h0004_8040);
    rateCode = 3'h7;
    repeat (5) @(negedge sys_clk);
    bank(BANK_TWO);
    wr(32'h0007_8040);
    rd(8'h40, 32'h0104_8040);
    wr(32'h0003_8040);
    repeat (3) @(negedge sys_clk);
    bank(BANK_THREE);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_bankset();
    t_stream();
    t_stopped();
    t_cut();
    t_auto();
    summarize();
  end
endmodule

// File: hw/coef_bank_pkg.sv
// constants shared by the coefficient bank switch controller and its store
// assumes the control-port slave has already decoded byte transfers into words
package coef_bank_pkg;

  localparam int          REG_ADDR_W      = 8;
  localparam int          REG_DATA_W      = 32;
  localparam logic [7:0]  BANK_CTRL_OFFSET = 8'h40;

  // field layout of bank_select_and_rate_map
  localparam int          SEL_LSB         = 16;
  localparam int          SEL_W           = 3;
  localparam int          MAP1_LSB        = 8;
  localparam int          MAP2_LSB        = 0;
  localparam int          MAP_W           = 8;
  localparam int          ACTIVE_LSB      = 24;
  localparam int          BUSY_BIT        = 26;

  // reset values
  localparam logic [2:0]  SEL_RESET       = 3'h0;
  localparam logic [7:0]  MAP1_RESET      = 8'hFF;
  localparam logic [7:0]  MAP2_RESET      = 8'h00;

  // selection codes
  localparam logic [2:0]  SEL_MANUAL_B1   = 3'h0;
  localparam logic [2:0]  SEL_MANUAL_B2   = 3'h1;
  localparam logic [2:0]  SEL_MANUAL_B3   = 3'h2;
  localparam logic [2:0]  SEL_AUTO        = 3'h3;
  localparam logic [2:0]  SEL_SET_B1      = 3'h4;
  localparam logic [2:0]  SEL_SET_B3      = 3'h6;

  // bank indices
  localparam int          BANK_W          = 2;
  localparam int          NUM_BANKS       = 3;
  localparam logic [1:0]  BANK_ONE        = 2'h0;
  localparam logic [1:0]  BANK_TWO        = 2'h1;
  localparam logic [1:0]  BANK_THREE      = 2'h2;

  // detected data rates, 32 kHz first through 192 kHz last
  localparam int          RATE_W          = 3;
  localparam int          NUM_RATES       = 8;

  // words per bank: 8 ch x 7 biquads x 5, loudness 5, two compressors 6 each,
  // five bass and five treble selections
  localparam int          BIQUAD_WORDS    = 280;
  localparam int          LOUD_WORDS      = 5;
  localparam int          COMP_WORDS      = 12;
  localparam int          TONE_WORDS      = 10;
  localparam int          BANK_WORDS      = BIQUAD_WORDS + LOUD_WORDS + COMP_WORDS + TONE_WORDS;
  localparam int          COEF_W          = 32;

  localparam int          NUM_CHANNELS    = 8;
  localparam int          VOL_W           = 16;

  typedef enum logic [1:0]
  {
    SW_IDLE   = 2'b00,
    SW_MUTE   = 2'b01,
    SW_UNMUTE = 2'b10
  } switch_state_t;

endpackage

// File: hw/coef_bank_store.sv
// three banks of sample-rate-dependent coefficients, one write and one read port
// assumes the caller picks the write bank and the read bank each cycle
`timescale 1ns/1ps

module coef_bank_store
#(
  parameter int WIDTH = coef_bank_pkg::COEF_W,
  parameter int DEPTH = coef_bank_pkg::BANK_WORDS,
  parameter int AW    = $clog2(coef_bank_pkg::BANK_WORDS)
)
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic                              wrEn,
  input  wire logic [coef_bank_pkg::BANK_W-1:0]  wrBank,
  input  wire logic [AW-1:0]                     wrAddr,
  input  wire logic [WIDTH-1:0]                  wrData,
  input  wire logic [coef_bank_pkg::BANK_W-1:0]  rdBank,
  input  wire logic [AW-1:0]                     rdAddr,
  output logic      [WIDTH-1:0]                  rdData
);
  import coef_bank_pkg::*;

  if (DEPTH < 1 || (1 << AW) < DEPTH || WIDTH < 1)
  begin : g_check
    $error("coef_bank_store: DEPTH does not fit AW or WIDTH is zero");
  end

  typedef struct packed
  {
    logic [WIDTH-1:0] rdData;
  } store_state_t;

  // contents are not reset: every bank holds unknown data until software writes it
  logic         [WIDTH-1:0] mem [NUM_BANKS][DEPTH];
  store_state_t             cur;
  store_state_t             next_cur;

  always_comb
  begin
    next_cur = cur;
    if (rdBank < BANK_W'(NUM_BANKS) && int'(rdAddr) < DEPTH)
      next_cur.rdData = mem[rdBank][rdAddr];
    else
      next_cur.rdData = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= next_cur;
    if (wrEn && wrBank < BANK_W'(NUM_BANKS) && int'(wrAddr) < DEPTH)
      mem[wrBank][wrAddr] <= wrData;
  end

  assign rdData = cur.rdData;

endmodule

// File: hw/coefficient_bank_switch_control.sv
// bank selection, bank-set protection and the mute/swap/unmute switch sequence
// assumes a control-port slave delivering word writes and reads, a rate detector
// and a volume ramp engine that acknowledges its mute and unmute ramps
`timescale 1ns/1ps

module coefficient_bank_switch_control
#(
  parameter int DEPTH = coef_bank_pkg::BANK_WORDS,
  parameter int AW    = $clog2(coef_bank_pkg::BANK_WORDS)
)
(
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst,
  input  wire logic                                       regWrEn,
  input  wire logic                                       regRdEn,
  input  wire logic [coef_bank_pkg::REG_ADDR_W-1:0]       regAddr,
  input  wire logic [coef_bank_pkg::REG_DATA_W-1:0]       regWrData,
  output logic      [coef_bank_pkg::REG_DATA_W-1:0]       regRdData,
  input  wire logic                                       coefWrEn,
  input  wire logic [AW-1:0]                              coefAddr,
  input  wire logic [coef_bank_pkg::COEF_W-1:0]           coefWrData,
  input  wire logic [AW-1:0]                              procRdAddr,
  output logic      [coef_bank_pkg::COEF_W-1:0]           procRdData,
  input  wire logic [coef_bank_pkg::RATE_W-1:0]           rateCode,
  input  wire logic                                       audioStreaming,
  input  wire logic                                       volWrEn,
  input  wire logic [$clog2(coef_bank_pkg::NUM_CHANNELS)-1:0] volChannel,
  input  wire logic [coef_bank_pkg::VOL_W-1:0]            volLevel,
  input  wire logic                                       muteDone,
  input  wire logic                                       unmuteDone,
  output logic                                            muteRequest,
  output logic [coef_bank_pkg::NUM_CHANNELS*coef_bank_pkg::VOL_W-1:0] volApplied,
  output logic      [coef_bank_pkg::BANK_W-1:0]           activeBank,
  output logic                                            switchBusy
);
  import coef_bank_pkg::*;

  localparam logic [VOL_W-1:0] MUTE_LEVEL = '0;

  typedef struct packed
  {
    logic [SEL_W-1:0]                   sel;
    logic [MAP_W-1:0]                   map1;
    logic [MAP_W-1:0]                   map2;
    logic [BANK_W-1:0]                  active;
    logic [BANK_W-1:0]                  pending;
    switch_state_t                      state;
    logic [NUM_CHANNELS-1:0][VOL_W-1:0] lastVol;
    logic [NUM_CHANNELS-1:0][VOL_W-1:0] applied;
    logic [REG_DATA_W-1:0]              rdData;
    logic                               mute;
    logic                               busy;
  } ctrl_state_t;

  ctrl_state_t       cur;
  ctrl_state_t       next_cur;
  logic [BANK_W-1:0] targetBank;
  logic [BANK_W-1:0] writeBank;
  logic              inhibit;

  // rate bit for code c sits at position 7-c, so 32 kHz is the top bit
  function automatic logic rateAssigned(input logic [MAP_W-1:0]  map,
                                        input logic [RATE_W-1:0] code);
    rateAssigned = map[RATE_W'(NUM_RATES - 1) - code];
  endfunction

  function automatic logic [BANK_W-1:0] autoBank(input logic [MAP_W-1:0]  m1,
                                                 input logic [MAP_W-1:0]  m2,
                                                 input logic [RATE_W-1:0] code);
    if (rateAssigned(m1, code))
      autoBank = BANK_ONE;
    else if (rateAssigned(m2, code))
      autoBank = BANK_TWO;
    else
      autoBank = BANK_THREE;
  endfunction

  always_comb
  begin
    inhibit = cur.sel >= SEL_SET_B1;
    case (cur.sel)
      SEL_MANUAL_B1, SEL_MANUAL_B2, SEL_MANUAL_B3:
        targetBank = cur.sel[BANK_W-1:0];
      SEL_AUTO:
        targetBank = autoBank(cur.map1, cur.map2, rateCode);
      default:
        targetBank = cur.active;
    endcase
    if (cur.sel <= SEL_MANUAL_B3)
      writeBank = cur.sel[BANK_W-1:0];
    else if (cur.sel == SEL_AUTO)
      writeBank = cur.active;
    else
      writeBank = BANK_W'(cur.sel - SEL_SET_B1);
  end

  always_comb
  begin
    next_cur = cur;

    if (regWrEn && regAddr == BANK_CTRL_OFFSET)
    begin
      // code 7 has no meaning, so the selection keeps its last value
      if (regWrData[SEL_LSB +: SEL_W] <= SEL_SET_B3)
        next_cur.sel = regWrData[SEL_LSB +: SEL_W];
      next_cur.map1 = regWrData[MAP1_LSB +: MAP_W];
      next_cur.map2 = regWrData[MAP2_LSB +: MAP_W];
    end

    if (regRdEn)
    begin
      next_cur.rdData = '0;
      if (regAddr == BANK_CTRL_OFFSET)
      begin
        next_cur.rdData[SEL_LSB +: SEL_W]     = cur.sel;
        next_cur.rdData[MAP1_LSB +: MAP_W]    = cur.map1;
        next_cur.rdData[MAP2_LSB +: MAP_W]    = cur.map2;
        next_cur.rdData[ACTIVE_LSB +: BANK_W] = cur.active;
        next_cur.rdData[BUSY_BIT]             = cur.busy;
      end
    end

    if (volWrEn)
      next_cur.lastVol[volChannel] = volLevel;

    case (cur.state)
      SW_IDLE:
      begin
        if (!inhibit && targetBank != cur.active)
        begin
          next_cur.pending = targetBank;
          if (audioStreaming)
          begin
            next_cur.state = SW_MUTE;
            next_cur.mute  = 1'b1;
            next_cur.busy  = 1'b1;
          end
          else
            next_cur.active = targetBank;
        end
      end
      SW_MUTE:
      begin
        // swap once muted, or at once if the clocks have stopped meanwhile
        if (muteDone || !audioStreaming)
        begin
          next_cur.active = cur.pending;
          next_cur.mute   = 1'b0;
          next_cur.state  = SW_UNMUTE;
        end
      end
      SW_UNMUTE:
      begin
        if (unmuteDone || !audioStreaming)
        begin
          next_cur.busy  = 1'b0;
          next_cur.state = SW_IDLE;
        end
      end
      default:
      begin
        next_cur.state = SW_IDLE;
        next_cur.mute  = 1'b0;
        next_cur.busy  = 1'b0;
      end
    endcase

    // volume writes during the switch mute are remembered but not applied
    for (int ch = 0; ch < NUM_CHANNELS; ch++)
    begin
      if (next_cur.mute)
        next_cur.applied[ch] = MUTE_LEVEL;
      else
        next_cur.applied[ch] = next_cur.lastVol[ch];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cur         <= '0;
      cur.sel     <= SEL_RESET;
      cur.map1    <= MAP1_RESET;
      cur.map2    <= MAP2_RESET;
      cur.active  <= BANK_ONE;
      cur.pending <= BANK_ONE;
      cur.state   <= SW_IDLE;
    end
    else
      cur <= next_cur;
  end

  coef_bank_store
  #(
    .WIDTH (COEF_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  )
  u_store
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wrEn    (coefWrEn),
    .wrBank  (writeBank),
    .wrAddr  (coefAddr),
    .wrData  (coefWrData),
    .rdBank  (cur.active),
    .rdAddr  (procRdAddr),
    .rdData  (procRdData)
  );

  assign regRdData   = cur.rdData;
  assign muteRequest = cur.mute;
  assign volApplied  = cur.applied;
  assign activeBank  = cur.active;
  assign switchBusy  = cur.busy;

endmodule
